/* sram_host.sv */
// host controller driving an asynchronous 16k x 4 static memory
// assumes the memory pins are wired straight to this block, shared data lines
//
// How it works
// - write begins at later falling edge; host drops select then strobe
// - host drives write data only after write-off delay after strobe falls
// - data held stable across strobe rise; strobe ends the write
// - select-ended writes measure setup and hold at select rise
// - address only changes while select or strobe is high
`timescale 1ns/1ns
`include "sram_host_defs.svh"
module sram_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic [`DATA_W-1:0] req_wdata,
  // read answer
  output logic rd_valid,
  output logic [`DATA_W-1:0] rd_data,
  // memory pins
  output logic sel_n,
  output logic wr_n,
  output logic [`ADDR_W-1:0] word_index_lines,
  output logic [`DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [`DATA_W-1:0] dq_i
);
  sram_host_pkg::state_e state_r, state_nxt;
  sram_host_pkg::pins_s pins_r, pins_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [`DATA_W-1:0] rd_data_r, rd_data_nxt;

  always_comb
  begin
    state_nxt = state_r;
    pins_nxt = pins_r;
    cnt_nxt = cnt_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    unique case (state_r)
      sram_host_pkg::ST_IDLE:
      begin
        // both strobes high so the address may move
        pins_nxt.sel_n = 1'b1;
        pins_nxt.wr_n = 1'b1;
        pins_nxt.dq_oe = 1'b0;
        if (req_valid)
        begin
          pins_nxt.word_index_lines = req_addr;
          pins_nxt.dq_o = req_wdata;
          state_nxt = req_write ? sram_host_pkg::ST_WR_SEL : sram_host_pkg::ST_RD_SEL;
        end
      end
      sram_host_pkg::ST_RD_SEL:
      begin
        // address stable one cycle before select falls
        pins_nxt.sel_n = 1'b0;
        cnt_nxt = `CNT_W'(`RD_ACC_CYC);
        state_nxt = sram_host_pkg::ST_RD_WAIT;
      end
      sram_host_pkg::ST_RD_WAIT:
      begin
        // fixed wait is safe since access time ignores deselect length
        if (cnt_r > `CNT_W'(1))
        begin
          cnt_nxt = cnt_r - `CNT_W'(1);
        end
        else
        begin
          rd_data_nxt = dq_i;
          rd_valid_nxt = 1'b1;
          pins_nxt.sel_n = 1'b1;
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      end
      sram_host_pkg::ST_WR_SEL:
      begin
        // select first, strobe falls later and starts the write
        pins_nxt.sel_n = 1'b0;
        state_nxt = sram_host_pkg::ST_WR_OFF;
      end
      sram_host_pkg::ST_WR_OFF:
      begin
        pins_nxt.wr_n = 1'b0;
        cnt_nxt = `CNT_W'(`WR_OFF_CYC);
        state_nxt = sram_host_pkg::ST_WR_DATA;
      end
      sram_host_pkg::ST_WR_DATA:
      begin
        // memory may still drive the lines; hold off to avoid contention
        if (cnt_r > `CNT_W'(1))
        begin
          cnt_nxt = cnt_r - `CNT_W'(1);
        end
        else
        begin
          pins_nxt.dq_oe = 1'b1;
          cnt_nxt = `CNT_W'(`WR_PULSE_CYC);
          state_nxt = sram_host_pkg::ST_WR_END;
        end
      end
      sram_host_pkg::ST_WR_END:
      begin
        if (cnt_r > `CNT_W'(1))
        begin
          cnt_nxt = cnt_r - `CNT_W'(1);
        end
        else
        begin
          // strobe rises with data still driven: hold time met
          pins_nxt.wr_n = 1'b1;
          pins_nxt.sel_n = 1'b1;
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      end
      default:
      begin
        // unused state code: drop to a deselected idle rather than hang
        pins_nxt.sel_n = 1'b1;
        pins_nxt.wr_n = 1'b1;
        pins_nxt.dq_oe = 1'b0;
        state_nxt = sram_host_pkg::ST_IDLE;
      end
    endcase
    if (state_r == sram_host_pkg::ST_IDLE && pins_r.dq_oe)
    begin
      pins_nxt.dq_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= sram_host_pkg::ST_IDLE;
      pins_r <= '{sel_n: 1'b1, wr_n: 1'b1, word_index_lines: '0, dq_o: '0, dq_oe: 1'b0};
      cnt_r <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // data lines released one cycle after write ends so memory may drive again
  assign req_ready = (state_r == sram_host_pkg::ST_IDLE) && !pins_r.dq_oe;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign sel_n = pins_r.sel_n;
  assign wr_n = pins_r.wr_n;
  assign word_index_lines = pins_r.word_index_lines;
  assign dq_o = pins_r.dq_o;
  assign dq_oe = pins_r.dq_oe;

  sequence s_strobe_fall;
    !sel_n && $fell(wr_n);
  endsequence

  sequence s_read_start;
    $fell(sel_n) && wr_n ##1 wr_n;
  endsequence

  a_addr_stable_sel: assert property (@(posedge sys_clk) disable iff (rst)
    (!sel_n && !wr_n) |-> $stable(word_index_lines))
    else $error("address moved during write");
  a_write_order: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(wr_n) |-> !$past(sel_n))
    else $error("strobe fell before select");
  a_no_early_drive: assert property (@(posedge sys_clk) disable iff (rst)
    s_strobe_fall |-> !dq_oe [*1] ##1 1)
    else $error("data driven before output-off delay");
  a_data_at_rise: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(wr_n) |-> $past(dq_oe) && dq_oe)
    else $error("data not held across strobe rise");
  a_pulse_width: assert property (@(posedge sys_clk) disable iff (rst)
    s_strobe_fall |-> !wr_n [*3])
    else $error("write pulse too short");
  a_drive_only_write: assert property (@(posedge sys_clk) disable iff (rst)
    dq_oe |-> (!wr_n || !$past(wr_n)))
    else $error("data driven outside write");
  a_read_wait: assert property (@(posedge sys_clk) disable iff (rst)
    s_read_start |-> !sel_n ##1 sel_n)
    else $error("read access wait wrong");
  a_idle_desel: assert property (@(posedge sys_clk) disable iff (rst)
    req_ready |-> sel_n && wr_n)
    else $error("ready while selected");
  a_rd_after_sel: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sel_n) |-> $stable(word_index_lines))
    else $error("address changed as select fell");
  a_sel_strobe_high: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sel_n) |-> wr_n)
    else $error("strobe low as select fell");
  a_end_together: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(wr_n) |-> $rose(sel_n))
    else $error("strobe and select did not rise together");
  a_data_release: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(wr_n) |=> !dq_oe)
    else $error("data lines not released after hold cycle");
  a_ready_after_wr: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(wr_n) |-> !req_ready ##1 req_ready)
    else $error("ready not back after write");
  a_rd_pulse_one: assert property (@(posedge sys_clk) disable iff (rst)
    rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_rd_sampled: assert property (@(posedge sys_clk) disable iff (rst)
    rd_valid |-> !$past(sel_n) && $past(wr_n))
    else $error("read data taken outside a read");
endmodule

/* sram_host_defs.svh */
// timing counts for the static memory host controller
// assumes a 25 MHz sys_clk (40 ns period)
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH
`define CLK_PERIOD_NS 40
// write-to-output-off delay, worst grade, ns
`define WR_OFF_NS 25
`define WR_OFF_CYC (((`WR_OFF_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// write pulse width, worst grade, ns
`define WR_PULSE_NS 50
`define WR_PULSE_CYC (((`WR_PULSE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// read access time, worst grade, ns
`define RD_ACC_NS 70
`define RD_ACC_CYC (((`RD_ACC_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define ADDR_W 14
`define DATA_W 4
`define CNT_W 4
`endif

/* sram_host_pkg.sv */
// types shared by the static memory host controller
// assumes sram_host_defs.svh is on the include path
`include "sram_host_defs.svh"
package sram_host_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RD_SEL, ST_RD_WAIT, ST_WR_SEL, ST_WR_OFF, ST_WR_DATA,
    ST_WR_END} state_e;
  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic [`ADDR_W-1:0] word_index_lines;
    logic [`DATA_W-1:0] dq_o;
    logic dq_oe;
  } pins_s;
endpackage

/* sram_dev_model.sv */
// behavioural 16k x 4 static memory answering the host pins
// assumes it is wired straight to sram_host; no clock of its own
`timescale 1ns/1ns
`include "sram_host_defs.svh"
module sram_dev_model (
  // host pins
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic [`ADDR_W-1:0] word_index_lines,
  input wire logic [`DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  // memory side of the data lines
  output logic [`DATA_W-1:0] dq_i,
  output logic drv
);
  logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
  logic [`DATA_W-1:0] last = 4'h0;
  logic [`DATA_W-1:0] wdat = 4'h0;
  logic [`ADDR_W-1:0] wadr = 14'h0000;
  logic blk = 1'b0;
  logic pend = 1'b0;
  logic live;
  always @(sel_n) blk = !sel_n && !wr_n;
  assign live = !sel_n && wr_n && !blk;
  // outputs linger for the off delay after the strobe falls, exposing early drive
  assign #(`WR_OFF_NS) drv = live;
  always @* if (live) last = mem[word_index_lines];
  // data settles one access time after select; released lines show the inverse
  assign #(`RD_ACC_NS) dq_i = live ? mem[word_index_lines] : ~last;
  always @(sel_n, wr_n, dq_o, dq_oe)
  begin
    if (!sel_n && !wr_n)
    begin
      pend = 1'b1;
      wadr = word_index_lines;
      if (dq_oe) wdat = dq_o;
    end
    else if (pend)
    begin
      mem[wadr] = wdat;
      pend = 1'b0;
    end
  end
endmodule

/* tb_top.sv */
// self-checking bench for sram_host against the memory model
// assumes sram_dev_model.sv and the design files are compiled first
`timescale 1ns/1ns
`include "sram_host_defs.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [13:0] req_addr = 14'h0000;
  logic [3:0] req_wdata = 4'h0;
  logic req_ready, rd_valid, sel_n, wr_n, dq_oe, drv;
  logic [3:0] rd_data, dq_o, dq_i;
  logic [13:0] word_index_lines;
  logic [13:0] hold_a = 14'h0000;
  int errors = 0;
  int checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  sram_host i_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .sel_n(sel_n),
    .wr_n(wr_n), .word_index_lines(word_index_lines), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i));
  sram_dev_model i_mem (.sel_n(sel_n), .wr_n(wr_n), .word_index_lines(word_index_lines),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .drv(drv));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // issue one request, return cycles from take to answer
  task automatic xfer(input logic w, input logic [13:0] a, input logic [3:0] d, output int n);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (n < 20 && (w ? req_ready !== 1'b1 : rd_valid !== 1'b1));
  endtask
  task automatic wr(input logic [13:0] a, input logic [3:0] d);
    int n;
    xfer(1'b1, a, d, n);
    chk("write span", 16'h0007, 16'(n));
  endtask
  task automatic rd(input logic [13:0] a, input logic [3:0] d);
    int n;
    xfer(1'b0, a, d, n);
    chk("read span", 16'h0004, 16'(n));
    chk("read data", {12'h000, d}, {12'h000, rd_data});
  endtask
  // shared lines and address must be quiet during a write
  always @(negedge sys_clk)
  begin
    if (!rst)
    begin
      chk("contention", 16'h0000, {15'h0000, drv & dq_oe});
      if (!sel_n && !wr_n)
        chk("addr held", {2'h0, hold_a}, {2'h0, word_index_lines});
      hold_a = word_index_lines;
    end
  end
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    chk("reset pins", 16'h000c, {12'h000, sel_n, wr_n, dq_oe, rd_valid});
    chk("reset ready", 16'h0001, {15'h0000, req_ready});
    rst <= 1'b0;
    wr(14'h0000, 4'ha);
    wr(14'h3fff, 4'h5);
    rd(14'h3fff, 4'h5);
    rd(14'h0000, 4'ha);
    wr(14'h0000, 4'h3);
    rd(14'h0000, 4'h3);
    rd(14'h3fff, 4'h5);
    chk("idle select", 16'h0003, {14'h0000, sel_n, wr_n});
    end_of_test();
  end
endmodule
